// >>> verilog/lsd_pkg.sv
// constants and types shared by the led sink control logic
package lsd_pkg;

  // shift register, latches and channel count
  localparam int SR_W  = 8;
  localparam int CFG_W = 8;
  localparam int CH_N  = 8;

  // two-entry buffer on the gain code update path
  localparam int BUF_DEPTH = 2;
  localparam int BUF_PTR_W = 1;
  localparam int BUF_CNT_W = 2;

  // reset values
  localparam logic [SR_W-1:0]  SR_RST    = 8'h00;
  localparam logic [SR_W-1:0]  OUT_RST   = 8'h00;
  localparam logic [CFG_W-1:0] CFG_RST   = 8'hff;
  localparam logic [1:0]       EN_H_RST  = 2'h3;
  localparam logic [CH_N-1:0]  SINK_RST  = 8'h00;
  localparam logic             LVL_RST   = 1'b0;

  // enable pin samples (oldest first) that form the trigger:
  // high, low for exactly one serial clock, high again
  localparam logic [2:0] TRIG_PATTERN = 3'h5;

  typedef enum logic [1:0] {
    PH_NORMAL = 2'b00,
    PH_SWITCH = 2'b01,
    PH_ADJUST = 2'b10
  } lsd_phase_t;

endpackage

// >>> verilog/lsd_buf2.sv
// two-entry valid/ready buffer
`timescale 1ns/1ps
module lsd_buf2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rstn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  import lsd_pkg::*;

  logic [WIDTH-1:0]     mem      [BUF_DEPTH];
  logic [WIDTH-1:0]     next_mem [BUF_DEPTH];
  logic [BUF_PTR_W-1:0] wr_ptr;
  logic [BUF_PTR_W-1:0] next_wr_ptr;
  logic [BUF_PTR_W-1:0] rd_ptr;
  logic [BUF_PTR_W-1:0] next_rd_ptr;
  logic [BUF_CNT_W-1:0] count;
  logic [BUF_CNT_W-1:0] next_count;
  logic                 do_push;
  logic                 do_pop;

  // honest flags straight from the fill count
  assign in_ready_o  = (count != BUF_CNT_W'(BUF_DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  always_comb begin
    do_push     = in_valid_i && in_ready_o;
    do_pop      = out_valid_o && out_ready_i;
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (do_push) begin
      next_mem[wr_ptr] = in_data_i;
      next_wr_ptr      = wr_ptr + 1'b1;
    end
    if (do_pop) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
    if (do_push && !do_pop) begin
      next_count = count + 1'b1;
    end else if (do_pop && !do_push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage needs no reset; empty flag guards it
  always_ff @(posedge clk_sys_i) begin
    mem <= next_mem;
  end

endmodule

// >>> verilog/lsd_ctrl.sv
// led sink driver control: shift chain, latches, phases
//
// Overview of operation
// - shift in serial bit on clock rise
// - normal mode: latch follows while strobe high
// - latched one sinks when enable is low
// - switching phase strobe never moves data
// - strobe high picks adjust, low picks normal
// - adjust mode strobe loads configuration latch
// - enable low drives sinks, high blanks all
// - one-clock enable pulse enters switching phase
// - trigger seen in every phase
// - last stage drives cascade output
// - eight channels, own bit, shared enable
// - eight-bit configuration code, 256 gain steps
`timescale 1ns/1ps
module lsd_ctrl (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rstn_i,
  input  wire logic                      serial_clk_i,
  input  wire logic                      serial_in_i,
  input  wire logic                      shared_strobe_pin_i,
  input  wire logic                      shared_enable_pin_n_i,
  output logic      [lsd_pkg::CH_N-1:0]  sink_channels_o,
  output logic                           serial_out_cascade_o,
  output logic      [lsd_pkg::CFG_W-1:0] gain_code_o,
  output lsd_pkg::lsd_phase_t            phase_o,
  output logic                           gain_upd_accept_o,
  output logic                           gain_upd_valid_o,
  input  wire logic                      gain_upd_ready_i,
  output logic      [lsd_pkg::CFG_W-1:0] gain_upd_data_o
);
  import lsd_pkg::*;

  // serial clock edge finder
  logic             clk_q;
  logic             next_clk_q;
  logic             clk_rise;

  // data path state
  logic [SR_W-1:0]  shreg;
  logic [SR_W-1:0]  next_shreg;
  logic [SR_W-1:0]  out_latch;
  logic [SR_W-1:0]  next_out_latch;
  logic [CFG_W-1:0] cfg_latch;
  logic [CFG_W-1:0] next_cfg_latch;
  logic [CH_N-1:0]  sink;
  logic [CH_N-1:0]  next_sink;

  // phase control state
  lsd_phase_t       phase;
  lsd_phase_t       next_phase;
  logic [1:0]       en_hist;
  logic [1:0]       next_en_hist;
  logic             strobe_q;
  logic             next_strobe_q;
  logic             trig_hit;

  // configuration update stream into the buffer
  logic             push_valid;
  logic             push_ready;

  //--------------------------------------------------------------
  // serial clock edge
  //--------------------------------------------------------------
  // pins are synchronous to clk_sys_i, so a plain delayed copy
  // is enough to find the rising edge of the serial clock
  always_comb begin
    next_clk_q = serial_clk_i;
    clk_rise   = serial_clk_i && !clk_q;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      clk_q <= LVL_RST;
    end else begin
      clk_q <= next_clk_q;
    end
  end

  //--------------------------------------------------------------
  // shift register and cascade output
  //--------------------------------------------------------------
  // shift on rise
  for (genvar b = 0; b < SR_W; b++) begin : g_shift
    logic stage_src;
    if (b == 0) begin : g_head
      assign stage_src = serial_in_i;
    end else begin : g_body
      assign stage_src = shreg[b-1];
    end
    always_comb begin
      next_shreg[b] = clk_rise ? stage_src : shreg[b];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      shreg <= SR_RST;
    end else begin
      shreg <= next_shreg;
    end
  end

  assign serial_out_cascade_o = shreg[SR_W-1];

  //--------------------------------------------------------------
  // trigger detection on the shared enable pin
  //--------------------------------------------------------------
  // only the levels seen at serial clock rises count, so a glitch
  // between rises can never start a mode switch
  always_comb begin
    next_en_hist = en_hist;
    if (clk_rise) begin
      next_en_hist = {en_hist[0], shared_enable_pin_n_i};
    end
    trig_hit = clk_rise &&
               ({en_hist, shared_enable_pin_n_i} == TRIG_PATTERN);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      en_hist <= EN_H_RST;
    end else begin
      en_hist <= next_en_hist;
    end
  end

  //--------------------------------------------------------------
  // phase sequencing
  //--------------------------------------------------------------
  always_comb begin
    next_phase = phase;
    unique case (phase)
      PH_NORMAL: begin
        next_phase = PH_NORMAL;
      end
      PH_ADJUST: begin
        next_phase = PH_ADJUST;
      end
      PH_SWITCH: begin
        if (clk_rise) begin
          if (shared_strobe_pin_i) begin
            next_phase = PH_ADJUST;
          end else begin
            next_phase = PH_NORMAL;
          end
        end
      end
      default: begin
        next_phase = PH_NORMAL;
      end
    endcase
    if (trig_hit) begin
      next_phase = PH_SWITCH;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      phase <= PH_NORMAL;
    end else begin
      phase <= next_phase;
    end
  end

  assign phase_o = phase;

  //--------------------------------------------------------------
  // output latch and configuration latch
  //--------------------------------------------------------------
  // each latch is transparent while the strobe is high in its own mode (output
  // latch in normal, configuration latch in adjust) and holds from the cycle the
  // strobe is seen low; data keeps shifting under an open latch, exactly as a
  // level latch would pass it through
  always_comb begin
    next_out_latch = out_latch;
    unique case (phase)
      PH_NORMAL: begin
        if (shared_strobe_pin_i) begin
          next_out_latch = shreg;
        end
      end
      PH_ADJUST: begin
        next_out_latch = out_latch;
      end
      PH_SWITCH: begin
        next_out_latch = out_latch;
      end
      default: begin
        next_out_latch = out_latch;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      out_latch <= OUT_RST;
    end else begin
      out_latch <= next_out_latch;
    end
  end

  always_comb begin
    next_cfg_latch = cfg_latch;
    unique case (phase)
      PH_NORMAL: begin
        next_cfg_latch = cfg_latch;
      end
      PH_ADJUST: begin
        if (shared_strobe_pin_i) begin
          next_cfg_latch = shreg;
        end
      end
      PH_SWITCH: begin
        next_cfg_latch = cfg_latch;
      end
      default: begin
        next_cfg_latch = cfg_latch;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cfg_latch <= CFG_RST;
    end else begin
      cfg_latch <= next_cfg_latch;
    end
  end

  // only a strobe seen high in adjust mode can close a code pulse;
  // the mode pick level still high as adjust starts is no pulse
  always_comb begin
    next_strobe_q = shared_strobe_pin_i && (phase == PH_ADJUST);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      strobe_q <= LVL_RST;
    end else begin
      strobe_q <= next_strobe_q;
    end
  end

  assign gain_code_o = cfg_latch;

  //--------------------------------------------------------------
  // sink channel gating
  //--------------------------------------------------------------
  // registered so the sink pins never glitch on a latch update
  for (genvar ch = 0; ch < CH_N; ch++) begin : g_sink
    always_comb begin
      next_sink[ch] = out_latch[ch] && !shared_enable_pin_n_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sink <= SINK_RST;
    end else begin
      sink <= next_sink;
    end
  end

  assign sink_channels_o = sink;

  //--------------------------------------------------------------
  // gain code update stream
  //--------------------------------------------------------------
  // each strobe pulse closing in adjust mode hands the new code to
  // the regulator side; the buffer absorbs two codes of stall, and
  // a third code during a longer stall is refused (accept low)
  always_comb begin
    push_valid = (phase == PH_ADJUST) && strobe_q &&
                 !shared_strobe_pin_i;
  end

  lsd_buf2 #(
    .WIDTH (CFG_W)
  ) u_gain_buf (
    .clk_sys_i   (clk_sys_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (cfg_latch),
    .out_valid_o (gain_upd_valid_o),
    .out_ready_i (gain_upd_ready_i),
    .out_data_o  (gain_upd_data_o)
  );

  assign gain_upd_accept_o = push_ready;

endmodule

// >>> sim/lsd_ctrl_assertions.sv
// assertions on the led sink control ports
`timescale 1ns/1ps
module lsd_ctrl_checker
  import lsd_pkg::*;
(
  input wire logic                      clk_sys_i,
  input wire logic                      rstn_i,
  input wire logic                      serial_clk_i,
  input wire logic                      serial_in_i,
  input wire logic                      shared_strobe_pin_i,
  input wire logic                      shared_enable_pin_n_i,
  input wire logic [lsd_pkg::CH_N-1:0]  sink_channels_o,
  input wire logic                      serial_out_cascade_o,
  input wire logic [lsd_pkg::CFG_W-1:0] gain_code_o,
  input wire lsd_pkg::lsd_phase_t       phase_o,
  input wire logic                      gain_upd_accept_o,
  input wire logic                      gain_upd_valid_o,
  input wire logic                      gain_upd_ready_i,
  input wire logic [lsd_pkg::CFG_W-1:0] gain_upd_data_o
);
  logic       sclk_q;
  logic       rise;
  logic       trig;
  logic [1:0] hist;
  logic [7:0] sr;
  logic [7:0] cap;
  assign rise = serial_clk_i & ~sclk_q;
  assign trig = rise & shared_enable_pin_n_i & (hist == 2'h2);
  // reference copy of the shift chain and enable history
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sclk_q <= 1'b0;
      hist   <= 2'h3;
      sr     <= 8'h00;
      cap    <= 8'h00;
    end else begin
      sclk_q <= serial_clk_i;
      if (rise) begin
        hist <= {hist[0], shared_enable_pin_n_i};
        sr   <= {sr[6:0], serial_in_i};
      end
      if (phase_o == PH_ADJUST && shared_strobe_pin_i) begin
        cap <= sr;
      end
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_cascade;
    serial_out_cascade_o == sr[7];
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("cascade bit wrong");
  property p_latch;
    (phase_o == PH_NORMAL && shared_strobe_pin_i && !shared_enable_pin_n_i)
      ##1 (!shared_strobe_pin_i && !shared_enable_pin_n_i)
      |=> sink_channels_o == $past(sr, 2);
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched sinks wrong");
  property p_blank;
    shared_enable_pin_n_i |=> sink_channels_o == 8'h00;
  endproperty
  a_blank: assert property (p_blank)
    else $error("sinks not blanked");
  property p_hold;
    (!shared_strobe_pin_i && !shared_enable_pin_n_i)[*2]
      |=> $stable(sink_channels_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("sinks moved without strobe");
  property p_trig;
    trig |=> phase_o == PH_SWITCH;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger missed");
  property p_pick;
    phase_o == PH_SWITCH && rise && !trig |=>
      phase_o == ($past(shared_strobe_pin_i) ? PH_ADJUST : PH_NORMAL);
  endproperty
  a_pick: assert property (p_pick)
    else $error("wrong mode picked");
  property p_cfg;
    (phase_o == PH_ADJUST && shared_strobe_pin_i) ##1 !shared_strobe_pin_i
      |-> ##[1:2] gain_code_o == cap;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("gain code not loaded");
  property p_switch_hold;
    phase_o == PH_SWITCH |=> $stable(gain_code_o);
  endproperty
  a_switch_hold: assert property (p_switch_hold)
    else $error("gain code moved while switching");
  property p_pick_quiet;
    $rose(phase_o == PH_ADJUST) && !gain_upd_valid_o |=> !gain_upd_valid_o;
  endproperty
  a_pick_quiet: assert property (p_pick_quiet)
    else $error("mode pick queued a code");
  property p_buf;
    gain_upd_valid_o && !gain_upd_ready_i
      |=> gain_upd_valid_o && $stable(gain_upd_data_o);
  endproperty
  a_buf: assert property (p_buf)
    else $error("buffered code lost");
  c_trig: cover property (trig);
  c_adj: cover property (phase_o == PH_ADJUST && gain_upd_valid_o);
  c_full: cover property (!gain_upd_accept_o);
endmodule
bind lsd_ctrl lsd_ctrl_checker u_chk (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .serial_clk_i(serial_clk_i),
  .serial_in_i(serial_in_i), .shared_strobe_pin_i(shared_strobe_pin_i),
  .shared_enable_pin_n_i(shared_enable_pin_n_i),
  .sink_channels_o(sink_channels_o),
  .serial_out_cascade_o(serial_out_cascade_o), .gain_code_o(gain_code_o),
  .phase_o(phase_o), .gain_upd_accept_o(gain_upd_accept_o),
  .gain_upd_valid_o(gain_upd_valid_o), .gain_upd_ready_i(gain_upd_ready_i),
  .gain_upd_data_o(gain_upd_data_o)
);

// >>> sim/lsd_host_model.sv
// display controller model driving the serial chain pins
`timescale 1ns/1ps
module lsd_host_model (
  input  wire logic clk_sys_i,
  output logic      serial_clk_o,
  output logic      serial_data_o,
  output logic      strobe_o,
  output logic      enable_n_o
);
  logic en_lvl;
  initial begin
    en_lvl = 1'b1;
    serial_clk_o = 1'b0;
    serial_data_o = 1'b0;
    strobe_o = 1'b0;
    enable_n_o = 1'b1;
  end
  task automatic tick(input logic d, input logic st, input logic en);
    @(negedge clk_sys_i);
    serial_clk_o = 1'b0;
    serial_data_o = d;
    strobe_o = st;
    enable_n_o = en;
    @(negedge clk_sys_i);
    serial_clk_o = 1'b1;
  endtask
  // clock stands low; data not held past its rise
  task automatic idle();
    @(negedge clk_sys_i);
    serial_clk_o = 1'b0;
    strobe_o = 1'b0;
    serial_data_o = ~serial_data_o;
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) tick(b[i], 1'b0, en_lvl);
    idle();
  endtask
  task automatic set_en(input logic v);
    @(negedge clk_sys_i);
    en_lvl = v;
    enable_n_o = v;
  endtask
  task automatic pulse();
    @(negedge clk_sys_i);
    strobe_o = 1'b1;
    @(negedge clk_sys_i);
    strobe_o = 1'b0;
  endtask
  // one-clock enable pulse, then strobe level picks mode
  task automatic trigger(input logic sel);
    tick(1'b0, 1'b0, 1'b1);
    tick(1'b0, 1'b0, 1'b0);
    tick(1'b0, 1'b0, 1'b1);
    tick(1'b0, sel, 1'b1);
    idle();
    en_lvl = 1'b1;
  endtask
endmodule

// >>> sim/lsd_ctrl_tb_top.sv
// testbench for the led sink control block
`timescale 1ns/1ps
module lsd_ctrl_tb_top;
  import lsd_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       rstn_i;
  logic       sclk, serial_in, stb, en_n, casc, acc, vld;
  logic       rdy;
  logic [7:0] sink, gcode, gdata;
  lsd_phase_t phase;
  int         errors = 0;
  int         checks = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  lsd_host_model u_host (
    .clk_sys_i     (clk_sys_i),
    .serial_clk_o  (sclk),
    .serial_data_o (serial_in),
    .strobe_o      (stb),
    .enable_n_o    (en_n)
  );
  lsd_ctrl u_dut (
    .clk_sys_i             (clk_sys_i),
    .rstn_i                (rstn_i),
    .serial_clk_i          (sclk),
    .serial_in_i           (serial_in),
    .shared_strobe_pin_i   (stb),
    .shared_enable_pin_n_i (en_n),
    .sink_channels_o       (sink),
    .serial_out_cascade_o  (casc),
    .gain_code_o           (gcode),
    .phase_o               (phase),
    .gain_upd_accept_o     (acc),
    .gain_upd_valid_o      (vld),
    .gain_upd_ready_i      (rdy),
    .gain_upd_data_o       (gdata)
  );
  task automatic chk(input string w, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic end_sim();
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic t_shift();
    logic [15:0] w;
    w = 16'ha53c;
    u_host.send(w[15:8]);
    for (int k = 0; k < 8; k++) begin
      u_host.tick(w[7-k], 1'b0, 1'b1);
      wt(1);
      chk("cascade", {7'h00, w[14-k]}, {7'h00, casc});
    end
    u_host.idle();
  endtask
  task automatic t_latch();
    u_host.set_en(1'b0);
    u_host.pulse();
    wt(3);
    chk("sink", 8'h3c, sink);
    u_host.send(8'h0f);
    wt(2);
    chk("hold", 8'h3c, sink);
    u_host.set_en(1'b1);
    wt(2);
    chk("blank", 8'h00, sink);
  endtask
  task automatic t_adjust();
    u_host.trigger(1'b1);
    chk("phase", {6'h00, PH_ADJUST}, {6'h00, phase});
    wt(2);
    chk("pick queued", 8'h00, {7'h00, vld});
    u_host.set_en(1'b0);
    u_host.send(8'h5a);
    u_host.pulse();
    wt(3);
    chk("gain", 8'h5a, gcode);
    chk("sink", 8'h3c, sink);
    u_host.send(8'hc3);
    u_host.pulse();
    u_host.send(8'h11);
    u_host.pulse();
    wt(3);
    chk("accept", 8'h00, {7'h00, acc});
    rdy = 1'b1;
    chk("first", 8'h5a, gdata);
    wt(1);
    chk("second", 8'hc3, gdata);
    wt(1);
    rdy = 1'b0;
    chk("valid", 8'h00, {7'h00, vld});
    u_host.trigger(1'b0);
    chk("phase", {6'h00, PH_NORMAL}, {6'h00, phase});
  endtask
  task automatic t_bad();
    u_host.tick(1'b0, 1'b0, 1'b1);
    u_host.tick(1'b0, 1'b0, 1'b0);
    u_host.tick(1'b0, 1'b0, 1'b0);
    u_host.tick(1'b0, 1'b0, 1'b1);
    u_host.idle();
    chk("phase", 8'h00, {6'h00, phase});
  endtask
  initial begin
    rstn_i = 1'b0;
    rdy = 1'b0;
    wt(16);
    rstn_i = 1'b1;
    chk("gain", 8'hff, gcode);
    t_shift();
    t_latch();
    t_adjust();
    t_bad();
    end_sim();
  end
  initial begin
    #20000;
    errors++;
    end_sim();
  end
endmodule
